// *** pkg/pioc_cfg.svh ***
// Register map, field positions and reset values of the port block
`ifndef PIOC_CFG_SVH
`define PIOC_CFG_SVH
`define PIOC_OFS_DATA 8'h00
`define PIOC_OFS_DIR 8'h04
`define PIOC_OFS_PULL 8'h08
`define PIOC_OFS_SLEW 8'h0c
`define PIOC_OFS_DRIVE 8'h10
`define PIOC_OFS_PWR 8'h14
`define PIOC_ADDR_BITS 8
`define PIOC_PWR_FLAG_BIT 3
`define PIOC_PWR_ACK_BIT 2
`define PIOC_RST_DATA 1'b0
`define PIOC_RST_DIR 1'b0
`define PIOC_RST_PULL 1'b0
`define PIOC_RST_SLEW 1'b1
`define PIOC_RST_DRIVE 1'b0
`define PIOC_HTRANS_NONSEQ 2'h2
`endif

// *** pkg/pioc_pkg.sv ***
// Types shared by the port block
package pioc_pkg;
  typedef enum logic [2:0] {
    PIOC_REG_DATA = 3'h0,
    PIOC_REG_DIR = 3'h1,
    PIOC_REG_PULL = 3'h2,
    PIOC_REG_SLEW = 3'h3,
    PIOC_REG_DRIVE = 3'h4,
    PIOC_REG_PWR = 3'h5,
    PIOC_REG_NONE = 3'h7
  } pioc_reg_type;
endpackage

// *** design/pioc_port.sv ***
// General-purpose I/O port with pin control, peripheral override and stop hold
//
// The implementer's own choices: the register offsets and register access over AHB-Lite.
`include "pioc_cfg.svh"

module pioc_port #(
  parameter int WIDTH = 8,
  parameter int OSC_IN_PIN = 6,
  parameter int OSC_OUT_PIN = 5
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Shared peripherals, same clock
  input wire logic [WIDTH-1:0] periph_en,
  input wire logic [WIDTH-1:0] periph_oe,
  input wire logic [WIDTH-1:0] periph_out,
  input wire logic [WIDTH-1:0] analog_en,
  input wire logic [WIDTH-1:0] kbi_en,
  input wire logic osc_en,
  // System power state
  input wire logic stop2_active,
  // Pads
  input wire logic [WIDTH-1:0] pad_in,
  output logic [WIDTH-1:0] pad_out,
  output logic [WIDTH-1:0] pad_oe_n,
  output logic [WIDTH-1:0] pad_pullup,
  output logic [WIDTH-1:0] pad_slew,
  output logic [WIDTH-1:0] pad_drive_hi,
  output logic [WIDTH-1:0] pin_level
);

  logic [WIDTH-1:0] port_data;
  logic [WIDTH-1:0] pin_dir;
  logic [WIDTH-1:0] pull_en;
  logic [WIDTH-1:0] slew_en;
  logic [WIDTH-1:0] drive_en;
  logic recovery_flag;
  logic stop2_q;
  logic [WIDTH-1:0] pin_meta;
  logic [WIDTH-1:0] pin_sync;
  logic wr_pend;
  pioc_pkg::pioc_reg_type wr_reg;

  // Address phase decode
  wire logic addr_take = hsel && hready && htrans == `PIOC_HTRANS_NONSEQ;
  wire logic [`PIOC_ADDR_BITS-1:0] ofs = haddr[`PIOC_ADDR_BITS-1:0];
  wire logic hi_zero = haddr[31:`PIOC_ADDR_BITS] == '0;
  wire pioc_pkg::pioc_reg_type sel_reg =
    !hi_zero ? pioc_pkg::PIOC_REG_NONE :
    ofs == `PIOC_OFS_DATA ? pioc_pkg::PIOC_REG_DATA :
    ofs == `PIOC_OFS_DIR ? pioc_pkg::PIOC_REG_DIR :
    ofs == `PIOC_OFS_PULL ? pioc_pkg::PIOC_REG_PULL :
    ofs == `PIOC_OFS_SLEW ? pioc_pkg::PIOC_REG_SLEW :
    ofs == `PIOC_OFS_DRIVE ? pioc_pkg::PIOC_REG_DRIVE :
    ofs == `PIOC_OFS_PWR ? pioc_pkg::PIOC_REG_PWR : pioc_pkg::PIOC_REG_NONE;
  wire logic rd_take = addr_take && !hwrite;
  wire logic [WIDTH-1:0] wdat = hwdata[WIDTH-1:0];

  // Data phase write strobes
  wire logic wr_data = wr_pend && wr_reg == pioc_pkg::PIOC_REG_DATA;
  wire logic wr_dir = wr_pend && wr_reg == pioc_pkg::PIOC_REG_DIR;
  wire logic wr_pull = wr_pend && wr_reg == pioc_pkg::PIOC_REG_PULL;
  wire logic wr_slew = wr_pend && wr_reg == pioc_pkg::PIOC_REG_SLEW;
  wire logic wr_drive = wr_pend && wr_reg == pioc_pkg::PIOC_REG_DRIVE;
  wire logic wr_ack = wr_pend && wr_reg == pioc_pkg::PIOC_REG_PWR &&
    hwdata[`PIOC_PWR_ACK_BIT];

  // Pins taken by the oscillator
  logic [WIDTH-1:0] osc_own;
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_osc
      assign osc_own[gi] = osc_en && (gi == OSC_IN_PIN || gi == OSC_OUT_PIN);
    end
  endgenerate

  // Per-pin ownership priority: oscillator, analog, keyboard, peripheral, port
  // analog and oscillator first
  wire logic [WIDTH-1:0] dig_live = ~analog_en & ~osc_own;
  wire logic [WIDTH-1:0] kbi_in = dig_live & kbi_en;
  wire logic [WIDTH-1:0] per_own = dig_live & ~kbi_en & periph_en;
  wire logic [WIDTH-1:0] gpio_own = dig_live & ~kbi_en & ~periph_en;
  wire logic [WIDTH-1:0] drive_on = (per_own & periph_oe) | (gpio_own & pin_dir);
  wire logic [WIDTH-1:0] out_val = (per_own & periph_oe & periph_out) |
    (~(per_own & periph_oe) & port_data);
  // pullup only on inputs without analog
  wire logic [WIDTH-1:0] pull_val = pull_en & ~drive_on & dig_live;
  // slew and drive matter only on outputs
  wire logic [WIDTH-1:0] slew_val = slew_en & drive_on;
  wire logic [WIDTH-1:0] dhi_val = drive_en & drive_on;

  wire logic [WIDTH-1:0] next_pad_out = stop2_active ? pad_out : out_val;
  wire logic [WIDTH-1:0] next_pad_oe_n = stop2_active ? pad_oe_n : ~drive_on;
  wire logic [WIDTH-1:0] next_pad_pullup = stop2_active ? pad_pullup : pull_val;
  wire logic [WIDTH-1:0] next_pad_slew = stop2_active ? pad_slew : slew_val;
  wire logic [WIDTH-1:0] next_pad_dhi = stop2_active ? pad_drive_hi : dhi_val;

  // read source per bit; direction bit picks latch or pin
  wire logic [WIDTH-1:0] data_rd = ~analog_en & ((pin_dir & port_data) |
    (~pin_dir & pin_sync));
  logic [31:0] pwr_rd;
  always_comb begin
    pwr_rd = '0;
    pwr_rd[`PIOC_PWR_FLAG_BIT] = recovery_flag;
  end
  wire logic [31:0] next_hrdata =
    !rd_take ? '0 :
    sel_reg == pioc_pkg::PIOC_REG_DATA ? 32'(data_rd) :
    sel_reg == pioc_pkg::PIOC_REG_DIR ? 32'(pin_dir) :
    sel_reg == pioc_pkg::PIOC_REG_PULL ? 32'(pull_en) :
    sel_reg == pioc_pkg::PIOC_REG_SLEW ? 32'(slew_en) :
    sel_reg == pioc_pkg::PIOC_REG_DRIVE ? 32'(drive_en) :
    sel_reg == pioc_pkg::PIOC_REG_PWR ? pwr_rd : '0;

  // Recovery flag: set on leaving stop2, set wins over acknowledge
  wire logic stop2_exit = stop2_q && !stop2_active;
  wire logic next_flag = stop2_exit ? 1'b1 : (wr_ack ? 1'b0 : recovery_flag);

  // Pad input synchroniser, two stages
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= pad_in;
      pin_sync <= pin_meta;
    end
  end

  // Bus phase tracking; zero wait state, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_reg <= pioc_pkg::PIOC_REG_NONE;
      hrdata <= '0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pend <= addr_take && hwrite;
      wr_reg <= sel_reg;
      hrdata <= next_hrdata;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // reset values; each register written on its own strobe
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_data <= {WIDTH{`PIOC_RST_DATA}};
      pin_dir <= {WIDTH{`PIOC_RST_DIR}};
      pull_en <= {WIDTH{`PIOC_RST_PULL}};
      slew_en <= {WIDTH{`PIOC_RST_SLEW}};
      drive_en <= {WIDTH{`PIOC_RST_DRIVE}};
    end else begin
      if (wr_data) port_data <= wdat;
      if (wr_dir) pin_dir <= wdat;
      if (wr_pull) pull_en <= wdat;
      if (wr_slew) slew_en <= wdat;
      if (wr_drive) drive_en <= wdat;
    end
  end

  // Pad and status flops; powered stop needs no special handling
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pad_out <= '0;
      pad_oe_n <= '1;
      pad_pullup <= '0;
      pad_slew <= '0;
      pad_drive_hi <= '0;
      pin_level <= '0;
      stop2_q <= 1'b0;
      recovery_flag <= 1'b0;
    end else begin
      pad_out <= next_pad_out;
      pad_oe_n <= next_pad_oe_n;
      pad_pullup <= next_pad_pullup;
      pad_slew <= next_pad_slew;
      pad_drive_hi <= next_pad_dhi;
      pin_level <= pin_sync & dig_live;
      stop2_q <= stop2_active;
      recovery_flag <= next_flag;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  wire logic gp0 = gpio_own[0];
  sequence s_rd_data;
    rd_take && sel_reg == pioc_pkg::PIOC_REG_DATA;
  endsequence

  a_dir_enables_driver: assert property (
    (gp0 && !stop2_active) |=> (pad_oe_n[0] == !$past(pin_dir[0])))
    else $error("direction bit did not set pad driver");
  a_read_pin_level: assert property (
    (s_rd_data and (!pin_dir[0] && !analog_en[0])) |=> hrdata[0] == $past(pin_sync[0]))
    else $error("input read did not return pin level");
  a_read_latch_value: assert property (
    (s_rd_data and (pin_dir[0] && !analog_en[0])) |=> hrdata[0] == $past(port_data[0]))
    else $error("output read did not return latch");
  a_analog_reads_zero: assert property (
    (s_rd_data and analog_en[0]) |=> !hrdata[0])
    else $error("analog pin read not zero");
  a_analog_wins_pin: assert property (
    (analog_en[0] && periph_en[0] && periph_oe[0] && !stop2_active) |=>
      pad_oe_n[0] && !pad_pullup[0])
    else $error("analog did not take pin");
  a_kbi_forces_input: assert property (
    (|kbi_in && !stop2_active) |=> &(pad_oe_n | ~$past(kbi_in)))
    else $error("keyboard pin driven");
  a_pullup_off_output: assert property (
    !pad_oe_n[0] |-> !pad_pullup[0])
    else $error("pullup on while driving");
  a_slew_output_only: assert property (
    pad_oe_n[0] |-> !pad_slew[0] && !pad_drive_hi[0])
    else $error("slew or drive on input pin");
  a_stop2_holds_pads: assert property (
    stop2_active |=> $stable(pad_out) && $stable(pad_oe_n))
    else $error("pads changed in stop2");
  a_ack_clears_flag: assert property (
    (wr_ack && !stop2_exit) |=> !recovery_flag ##1 !recovery_flag || $past(stop2_exit))
    else $error("acknowledge did not clear flag");
  a_exit_sets_flag: assert property (
    stop2_exit |=> recovery_flag)
    else $error("flag not set on stop2 exit");
  a_write_then_pin: assert property (
    (wr_data && gp0 && !stop2_active) ##1 (gp0 && !stop2_active) |=>
      pad_out[0] == $past(port_data[0]))
    else $error("written data not on pin");

endmodule

// *** verification/pioc_pads.sv ***
// Pad model: resolves each pin from core drive, outside drive and pullup
module pioc_pads (
  // Clock
  input wire logic hclk,
  // Core side
  input wire logic [7:0] pad_out,
  input wire logic [7:0] pad_oe_n,
  input wire logic [7:0] pad_pullup,
  // Outside world
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val,
  output logic [7:0] pad_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic flip = 1'b0;

  // Floating pins wander, so a missing pullup never reads as a clean level
  always @(posedge hclk) begin
    flip <= ~flip;
  end

  // core drive, then outside, then pullup
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!pad_oe_n[i]) pad_in[i] = pad_out[i];
      else if (ext_en[i]) pad_in[i] = ext_val[i];
      else if (pad_pullup[i]) pad_in[i] = 1'b1;
      else pad_in[i] = flip ^ i[0];
    end
  end
endmodule

// *** verification/test_parallel_io_pin_control.sv ***
// Self-checking bench for the port block
`include "pioc_cfg.svh"
module test_parallel_io_pin_control;
  timeunit 1ns;
  timeprecision 1ns;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd;
  logic hreadyout, hresp;
  logic osc_en = 1'b0, stop2_active = 1'b0;
  logic [7:0] periph_en = 8'h0, periph_oe = 8'h0, periph_out = 8'h0, analog_en = 8'h0;
  logic [7:0] kbi_en = 8'h0, ext_en = 8'hff, ext_val = 8'h3c;
  logic [7:0] pad_in, pad_out, pad_oe_n, pad_pullup, pad_slew, pad_drive_hi, pin_level;
  int errors = 0, checked = 0, cycles = 0;

  always #20 hclk = ~hclk;

  pioc_port #(.WIDTH(8), .OSC_IN_PIN(6), .OSC_OUT_PIN(5)) dut_u (.hclk, .hresetn, .hsel,
    .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata,
    .hreadyout, .hresp, .periph_en, .periph_oe, .periph_out, .analog_en, .kbi_en,
    .osc_en, .stop2_active, .pad_in, .pad_out, .pad_oe_n, .pad_pullup, .pad_slew,
    .pad_drive_hi, .pin_level);

  pioc_pads pads_u (.hclk, .pad_out, .pad_oe_n, .pad_pullup, .ext_en, .ext_val, .pad_in);

  task automatic close_out;
    if (errors == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Hang guard, runs take well under a thousand cycles
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      errors++;
      close_out;
    end
  end

  task automatic chk(input string n, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", n, exp, got);
    end
  endtask

  // One single word transfer; read data taken at the edge ending the data phase
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= `PIOC_HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(n, exp, rd);
  endtask

  // Covers two-flop sync on pads plus the registered pad stage
  task automatic settle;
    repeat (4) @(posedge hclk);
    #1;
  endtask

  task automatic pins(input logic [7:0] en, oe, pv, an, kb, input logic osc, st);
    @(posedge hclk);
    periph_en <= en;
    periph_oe <= oe;
    periph_out <= pv;
    analog_en <= an;
    kbi_en <= kb;
    osc_en <= osc;
    stop2_active <= st;
    settle;
  endtask

  task automatic t_reset;
    rchk("dir", `PIOC_OFS_DIR, 32'h0);
    rchk("pull", `PIOC_OFS_PULL, 32'h0);
    rchk("slew", `PIOC_OFS_SLEW, 32'hff);
    rchk("drive", `PIOC_OFS_DRIVE, 32'h0);
    rchk("pwr", `PIOC_OFS_PWR, 32'h0);
    rchk("unmapped", 8'h40, 32'h0);
    chk("oe_n", 8'hff, pad_oe_n);
    chk("pullup", 8'h0, pad_pullup);
    chk("resp", 32'h0, {31'h0, hresp});
    chk("ready", 32'h1, {31'h0, hreadyout});
  endtask

  task automatic t_dir_data;
    xfer(1'b1, `PIOC_OFS_DATA, 32'ha5);
    xfer(1'b1, `PIOC_OFS_DIR, 32'h0f);
    settle;
    chk("oe_n", 8'hf0, pad_oe_n);
    chk("out", 4'h5, pad_out[3:0]);
    rchk("mixed", `PIOC_OFS_DATA, 32'h35);
    xfer(1'b1, `PIOC_OFS_DIR, 32'hff);
    settle;
    rchk("latch", `PIOC_OFS_DATA, 32'ha5);
  endtask

  task automatic t_periph;
    pins(8'h03, 8'h01, 8'h00, 8'h00, 8'h00, 1'b0, 1'b0);
    chk("oe_n", 8'h02, pad_oe_n);
    chk("out", 8'ha4, pad_out & 8'hfd);
    xfer(1'b1, `PIOC_OFS_PULL, 32'hff);
    settle;
    chk("pullup", 8'h02, pad_pullup);
    rchk("data", `PIOC_OFS_DATA, 32'ha5);
  endtask

  task automatic t_analog;
    pins(8'h03, 8'h01, 8'h00, 8'h01, 8'h04, 1'b1, 1'b0);
    chk("oe_n", 8'h67, pad_oe_n);
    chk("pullup", 8'h06, pad_pullup & 8'h9f);
    chk("level", 8'h00, pin_level & 8'h61);
    rchk("data", `PIOC_OFS_DATA, 32'ha4);
    pins(8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0, 1'b0);
  endtask

  task automatic t_ctrl;
    xfer(1'b1, `PIOC_OFS_SLEW, 32'h00);
    xfer(1'b1, `PIOC_OFS_DRIVE, 32'hff);
    settle;
    chk("slew", 8'h00, pad_slew);
    chk("drive", 8'hff, pad_drive_hi);
    rchk("dir", `PIOC_OFS_DIR, 32'hff);
    rchk("data", `PIOC_OFS_DATA, 32'ha5);
    xfer(1'b1, `PIOC_OFS_SLEW, 32'hff);
    xfer(1'b1, `PIOC_OFS_DIR, 32'h00);
    settle;
    chk("slew_in", 8'h00, pad_slew);
    chk("drive_in", 8'h00, pad_drive_hi);
    @(posedge hclk);
    ext_en <= 8'h00;
    settle;
    rchk("pulled", `PIOC_OFS_DATA, 32'hff);
    @(posedge hclk);
    ext_en <= 8'hff;
  endtask

  task automatic t_stop;
    xfer(1'b1, `PIOC_OFS_DIR, 32'hff);
    pins(8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0, 1'b1);
    xfer(1'b1, `PIOC_OFS_DATA, 32'h5a);
    settle;
    chk("held", 8'ha5, pad_out);
    pins(8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0, 1'b0);
    chk("woke", 8'h5a, pad_out);
    rchk("flag", `PIOC_OFS_PWR, 32'h8);
    xfer(1'b1, `PIOC_OFS_PWR, 32'h4);
    rchk("acked", `PIOC_OFS_PWR, 32'h0);
  endtask

  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset;
    t_dir_data;
    t_periph;
    t_analog;
    t_ctrl;
    t_stop;
    close_out;
  end
endmodule
